// [pkg/aigs_defs.svh]
// Purpose: Constants for the analog input and gain select block
// Assumes: Included by bare name; definitions only
// Notes:   Register port is a plain strobe port; offsets are word indices
`ifndef AIGS_DEFS_SVH
`define AIGS_DEFS_SVH
`define AIGS_ADDR_W          4
`define AIGS_OFF_INPUT       4'h0
`define AIGS_OFF_GAIN        4'h1
`define AIGS_OFF_CLAMP       4'h2
`define AIGS_OFF_STATUS      4'h3
`define AIGS_INPUT_RST       3'h0
`define AIGS_GAIN_RST        3'h0
`define AIGS_CLAMP_RST       2'h0
`define AIGS_CODE_SLEEP      3'h7
`define AIGS_CODE_SV1        3'h5
`define AIGS_CODE_SV2        3'h6
// Clamp field: [1:0] mode, [2] pedestal request
`define AIGS_CLAMP_PED_BIT   2
// Gain register: [2:0] manual gain code, [3] agc enable
`define AIGS_GAIN_AGC_BIT    3
`define AIGS_GAIN_AGC_RST    1'h1
// Input register: [2:0] input code, [3] single rate sampling
`define AIGS_INPUT_RATE_BIT  3
`define AIGS_INPUT_RATE_RST  1'h0
`endif

// [pkg/aigs_pkg.sv]
// Purpose: Types for the analog input and gain select block
// Assumes: Nothing
// Notes:   Constants live in aigs_defs.svh
package aigs_pkg;
	// Clamp modes
	typedef enum logic [1:0] {
		AIGS_CLAMP_ANALOG  = 2'h0,
		AIGS_CLAMP_HYBRID  = 2'h1,
		AIGS_CLAMP_DIGITAL = 2'h2
	} aigs_clamp_t;
	// One-hot source state
	typedef enum logic [1:0] {
		AIGS_SRC_PINS = 2'h1,
		AIGS_SRC_REGS = 2'h2
	} aigs_src_t;
	// Front end controls
	typedef struct packed {
		logic [5:0] vin_luma;
		logic [5:0] vin_chroma;
		logic       conv1_on;
		logic       conv2_on;
		logic       sleep;
	} aigs_route_t;
	// Gain controls
	typedef struct packed {
		logic [2:0] gain_code;
		logic       gain_valid;
		logic       agc_analog;
		logic       agc_digital;
	} aigs_gain_t;
endpackage

// [design/aigs_decode.sv]
// Purpose: Decode input code to multiplexer and converter controls
// Assumes: Code already chosen between pins and register
// Notes:   Pure combinational; caller registers the result
`timescale 1ns/1ps
`include "aigs_defs.svh"
module aigs_decode
	import aigs_pkg::*;
(
	// Code in
	input  wire logic [2:0]  code_in,
	// Decoded controls out
	output aigs_route_t      route_out
);
	// One-hot select of an input number 1..6
	function automatic logic [5:0] sel(input logic [2:0] n);
		sel = 6'h01 << (n - 3'h1);
	endfunction

	// Decoded pieces, joined into the bundle by one assignment
	logic [5:0] luma_sel;   // One-hot luma or composite source
	logic [5:0] chroma_sel; // One-hot chroma source
	logic       conv1;      // First converter runs
	logic       conv2;      // Second converter runs
	logic       asleep;     // Whole front end powered down

	// Luma path: composite input or S-video luma
	assign luma_sel =
		(code_in == `AIGS_CODE_SLEEP) ? 6'h00 :
		(code_in == `AIGS_CODE_SV1)   ? sel(3'h1) :
		(code_in == `AIGS_CODE_SV2)   ? sel(3'h2) :
		sel(code_in + 3'h1);
	// Chroma path only for S-video
	assign chroma_sel =
		(code_in == `AIGS_CODE_SV1) ? sel(3'h5) :
		(code_in == `AIGS_CODE_SV2) ? sel(3'h6) : 6'h00;
	assign conv1  = (code_in != `AIGS_CODE_SLEEP);
	assign conv2  = (code_in == `AIGS_CODE_SV1) ||
		(code_in == `AIGS_CODE_SV2);
	assign asleep = (code_in == `AIGS_CODE_SLEEP);
	// One driver for the whole bundle, member writes would clash
	assign route_out = {luma_sel, chroma_sel, conv1, conv2, asleep};
endmodule

// [design/aigs_top.sv]
// Purpose: Analog front end input, gain, clamp and rate control
// Assumes: Synchronous active low reset; one 25 MHz clock
// Notes:   Outputs registered one cycle after pin changes, two cycles after a register write
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "aigs_defs.svh"
module aigs_top
	import aigs_pkg::*;
(
	// Clock and reset
	input  wire logic                   REF_CLK_IN,
	input  wire logic                   RESETN_IN,
	// Straps and selection pins
	input  wire logic                   SRC_REG_MODE_IN,
	input  wire logic [2:0]             INPUT_CHOICE_PINS_IN,
	input  wire logic [2:0]             GAIN_CHOICE_PINS_IN,
	// Register port
	input  wire logic [`AIGS_ADDR_W-1:0] ADDR_IN,
	input  wire logic [7:0]             WDATA_IN,
	input  wire logic                   WR_IN,
	input  wire logic                   RD_IN,
	output logic      [7:0]             RDATA_OUT,
	// Front end controls
	output logic      [5:0]             VIDEO_LUMA_SEL_OUT,
	output logic      [5:0]             VIDEO_CHROMA_SEL_OUT,
	output logic                        CONV1_ON_OUT,
	output logic                        CONV2_ON_OUT,
	output logic                        SLEEP_OUT,
	output logic      [2:0]             GAIN_CODE_OUT,
	output logic                        GAIN_VALID_OUT,
	output logic                        AGC_ANALOG_OUT,
	output logic                        AGC_DIGITAL_OUT,
	output logic      [1:0]             CLAMP_MODE_OUT,
	output logic                        PEDESTAL_CLAMP_OUT,
	output logic                        CONV_DOUBLE_RATE_OUT
);
	// Register fields
	logic [2:0]  input_choice_field;   // Input code
	logic        single_rate;          // Converter rate select
	logic [2:0]  gain_choice_field;    // Manual gain code
	logic        agc_enable;           // Automatic gain enable
	logic [1:0]  clamp_mode_field;     // Clamp mode
	logic        pedestal_req;         // Pedestal clamp request
	aigs_src_t   src_state;            // Which source drives codes

	// Write decodes, one named wire each
	wire wr_input = WR_IN && (ADDR_IN == `AIGS_OFF_INPUT);
	wire wr_gain  = WR_IN && (ADDR_IN == `AIGS_OFF_GAIN);
	wire wr_clamp = WR_IN && (ADDR_IN == `AIGS_OFF_CLAMP);

	// Register writes; reserved clamp code 3 is kept as written
	always_ff @(posedge REF_CLK_IN) begin
		if (!RESETN_IN) begin
			input_choice_field <= `AIGS_INPUT_RST;
			single_rate        <= `AIGS_INPUT_RATE_RST;
			gain_choice_field  <= `AIGS_GAIN_RST;
			agc_enable         <= `AIGS_GAIN_AGC_RST;
			clamp_mode_field   <= `AIGS_CLAMP_RST;
			pedestal_req       <= 1'h0;
		end else begin
			if (wr_input) begin
				input_choice_field <= WDATA_IN[2:0];
				single_rate <= WDATA_IN[`AIGS_INPUT_RATE_BIT];
			end
			if (wr_gain) begin
				gain_choice_field <= WDATA_IN[2:0];
				agc_enable <= WDATA_IN[`AIGS_GAIN_AGC_BIT];
			end
			if (wr_clamp) begin
				clamp_mode_field <= WDATA_IN[1:0];
				pedestal_req <= WDATA_IN[`AIGS_CLAMP_PED_BIT];
			end
		end
	end

	// Source state follows the mode pin each cycle
	aigs_src_t next_src_state;
	assign next_src_state =
		SRC_REG_MODE_IN ? AIGS_SRC_REGS : AIGS_SRC_PINS;
	always_ff @(posedge REF_CLK_IN) begin
		if (!RESETN_IN)
			src_state <= AIGS_SRC_PINS;
		else
			src_state <= next_src_state;
	end

	// Chosen codes; pin mode never looks at the fields
	logic [2:0] in_code;
	logic [2:0] gain_code;
	always_comb begin
		case (next_src_state)
			AIGS_SRC_REGS: begin
				in_code   = input_choice_field;
				gain_code = gain_choice_field;
			end
			AIGS_SRC_PINS: begin
				in_code   = INPUT_CHOICE_PINS_IN;
				gain_code = GAIN_CHOICE_PINS_IN;
			end
			default: begin
				in_code   = INPUT_CHOICE_PINS_IN;
				gain_code = GAIN_CHOICE_PINS_IN;
			end
		endcase
	end

	// Decode the input code
	aigs_route_t route;
	aigs_decode u_decode (
		.code_in   (in_code),
		.route_out (route)
	);

	// Pedestal clamp allowed only with digital clamp
	wire pedestal_ok = pedestal_req &&
		(clamp_mode_field == AIGS_CLAMP_DIGITAL);

	// Gain bundle; code 111 flagged as not valid
	wire gain_ok = (gain_code != 3'h7);
	wire agc_dig = agc_enable && !pedestal_ok;
	aigs_gain_t gain;
	// One driver for the whole bundle
	assign gain = {gain_code, gain_ok, agc_enable, agc_dig};

	// Registered outputs, refreshed every cycle
	always_ff @(posedge REF_CLK_IN) begin
		if (!RESETN_IN) begin
			VIDEO_LUMA_SEL_OUT   <= 6'h00;
			VIDEO_CHROMA_SEL_OUT <= 6'h00;
			CONV1_ON_OUT         <= 1'h0;
			CONV2_ON_OUT         <= 1'h0;
			SLEEP_OUT            <= 1'h1;
			GAIN_CODE_OUT        <= 3'h0;
			GAIN_VALID_OUT       <= 1'h0;
			AGC_ANALOG_OUT       <= 1'h0;
			AGC_DIGITAL_OUT      <= 1'h0;
			CLAMP_MODE_OUT       <= 2'h0;
			PEDESTAL_CLAMP_OUT   <= 1'h0;
			CONV_DOUBLE_RATE_OUT <= 1'h1;
		end else begin
			VIDEO_LUMA_SEL_OUT   <= route.vin_luma;
			VIDEO_CHROMA_SEL_OUT <= route.vin_chroma;
			CONV1_ON_OUT         <= route.conv1_on;
			CONV2_ON_OUT         <= route.conv2_on;
			SLEEP_OUT            <= route.sleep;
			GAIN_CODE_OUT        <= gain.gain_code;
			GAIN_VALID_OUT       <= gain.gain_valid;
			AGC_ANALOG_OUT       <= gain.agc_analog;
			AGC_DIGITAL_OUT      <= gain.agc_digital;
			CLAMP_MODE_OUT       <= clamp_mode_field;
			PEDESTAL_CLAMP_OUT   <= pedestal_ok;
			CONV_DOUBLE_RATE_OUT <= !single_rate;
		end
	end

	// Read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		(ADDR_IN == `AIGS_OFF_INPUT) ?
			{4'h0, single_rate, input_choice_field} :
		(ADDR_IN == `AIGS_OFF_GAIN) ?
			{4'h0, agc_enable, gain_choice_field} :
		(ADDR_IN == `AIGS_OFF_CLAMP) ?
			{5'h00, pedestal_req, clamp_mode_field} :
		(ADDR_IN == `AIGS_OFF_STATUS) ?
			{1'h0, SLEEP_OUT, CONV2_ON_OUT, CONV1_ON_OUT,
			 src_state == AIGS_SRC_REGS, GAIN_CODE_OUT} :
			8'h00;
	always_ff @(posedge REF_CLK_IN) begin
		if (!RESETN_IN)
			RDATA_OUT <= 8'h00;
		else
			RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
	end

	// Checks
	property p_pin_mode;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		!SRC_REG_MODE_IN |=> GAIN_CODE_OUT == $past(GAIN_CHOICE_PINS_IN);
	endproperty
	a_pin_mode: assert property (p_pin_mode)
		else $error("pin mode gain mismatch");
	property p_reg_mode;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		SRC_REG_MODE_IN |=> GAIN_CODE_OUT == $past(gain_choice_field);
	endproperty
	a_reg_mode: assert property (p_reg_mode)
		else $error("register mode gain mismatch");
	property p_sleep;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		in_code == 3'h7 |=> SLEEP_OUT && !CONV1_ON_OUT && !CONV2_ON_OUT
			&& VIDEO_LUMA_SEL_OUT == 6'h00;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep decode wrong");
	property p_comp;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		in_code < 3'h5 |=> CONV1_ON_OUT && !CONV2_ON_OUT &&
			VIDEO_LUMA_SEL_OUT == (6'h01 << $past(in_code));
	endproperty
	a_comp: assert property (p_comp)
		else $error("composite decode wrong");
	property p_sv1;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		in_code == 3'h5 |=> VIDEO_LUMA_SEL_OUT == 6'h01 &&
			VIDEO_CHROMA_SEL_OUT == 6'h10 && CONV2_ON_OUT;
	endproperty
	a_sv1: assert property (p_sv1)
		else $error("svideo 1 decode wrong");
	property p_sv2;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		in_code == 3'h6 |=> VIDEO_LUMA_SEL_OUT == 6'h02 &&
			VIDEO_CHROMA_SEL_OUT == 6'h20 && CONV1_ON_OUT;
	endproperty
	a_sv2: assert property (p_sv2)
		else $error("svideo 2 decode wrong");
	property p_ped;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		PEDESTAL_CLAMP_OUT |-> CLAMP_MODE_OUT == 2'h2;
	endproperty
	a_ped: assert property (p_ped)
		else $error("pedestal outside digital clamp");
	property p_rst;
		@(posedge REF_CLK_IN)
		!RESETN_IN |=> input_choice_field == 3'h0 && CONV_DOUBLE_RATE_OUT;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset defaults wrong");
	property p_rate;
		@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		wr_input ##1 1'b1 |=> CONV_DOUBLE_RATE_OUT ==
			!$past(WDATA_IN[3], 2);
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate select wrong");
	c_sv1:   cover property (@(posedge REF_CLK_IN) in_code == 3'h5);
	c_sleep: cover property (@(posedge REF_CLK_IN) SLEEP_OUT && RESETN_IN);
	c_ped:   cover property (@(posedge REF_CLK_IN) PEDESTAL_CLAMP_OUT);
endmodule

// [verification/aigs_fe_model.sv]
// Purpose: Model of the input multiplexer and the two converters
// Assumes: Route controls are registered levels from the block
// Notes:   Flags any control set the analog side cannot take
`timescale 1ns/1ps
module aigs_fe_model
	import aigs_pkg::*;
(
	// Controls from the block
	input  wire logic [5:0] luma_sel_in,
	input  wire logic [5:0] chroma_sel_in,
	input  wire logic       conv1_on_in,
	input  wire logic       conv2_on_in,
	input  wire logic       sleep_in,
	// Verdict
	output logic            fault_out
);
	logic multi;   // Two sources on one path would short the inputs
	logic bad_lu;  // Converter one runs only with a luma source
	logic bad_ch;  // Chroma needs converter two, and only chroma does
	logic bad_slp; // Sleep must leave both converters off
	assign multi   = ($countones(luma_sel_in) > 1) ||
	                 ($countones(chroma_sel_in) > 1);
	assign bad_lu  = (luma_sel_in != 6'h00) != conv1_on_in;
	assign bad_ch  = (chroma_sel_in != 6'h00) != conv2_on_in;
	assign bad_slp = sleep_in && (conv1_on_in || conv2_on_in);
	assign fault_out = multi || bad_lu || bad_ch || bad_slp;
endmodule

// [verification/aigs_top_test.sv]
// Purpose: Self-checking bench for the input, gain and clamp control
// Assumes: Outputs settle within two edges of any input change
// Notes:   Pins are swept in pin mode and register fields in register mode
`timescale 1ns/1ps
`include "aigs_defs.svh"
module aigs_top_test;
	import aigs_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, src = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [2:0] ins = 3'h0, gns = 3'h0;
	logic [`AIGS_ADDR_W-1:0] addr = '0;
	logic [7:0] wdata = 8'h00, rdata;
	logic [5:0] luma, chroma;
	logic c1, c2, slp, gv, agca, agcd, ped, dbl, fault;
	logic [2:0] gc;
	logic [1:0] cm;
	logic exp_ped; // Expected pedestal clamp for a clamp write
	int n_fail = 0, compares = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	aigs_top uut (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .SRC_REG_MODE_IN(src),
		.INPUT_CHOICE_PINS_IN(ins), .GAIN_CHOICE_PINS_IN(gns),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .VIDEO_LUMA_SEL_OUT(luma),
		.VIDEO_CHROMA_SEL_OUT(chroma), .CONV1_ON_OUT(c1),
		.CONV2_ON_OUT(c2), .SLEEP_OUT(slp), .GAIN_CODE_OUT(gc),
		.GAIN_VALID_OUT(gv), .AGC_ANALOG_OUT(agca),
		.AGC_DIGITAL_OUT(agcd), .CLAMP_MODE_OUT(cm),
		.PEDESTAL_CLAMP_OUT(ped), .CONV_DOUBLE_RATE_OUT(dbl));
	// Far side watches what the block asks of it
	aigs_fe_model fe (.luma_sel_in(luma), .chroma_sel_in(chroma),
		.conv1_on_in(c1), .conv2_on_in(c2), .sleep_in(slp),
		.fault_out(fault));
	// Verdict in one place
	task automatic final_report();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle strobes, changed just after the edge
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk({8'h00, rdata}, {8'h00, e});
	endtask
	// Register writes need two edges to reach the outputs
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Expected luma, chroma, conv1, conv2, sleep for an input code
	function automatic logic [14:0] exp_route(input logic [2:0] c);
		case (c)
			3'h5: return {6'h01, 6'h10, 3'b110};
			3'h6: return {6'h02, 6'h20, 3'b110};
			3'h7: return {12'h000, 3'b001};
			default: return {6'h01 << c, 6'h00, 3'b100};
		endcase
	endfunction
	task automatic chk_route(input logic [2:0] c);
		chk({1'b0, luma, chroma, c1, c2, slp}, {1'b0, exp_route(c)});
		chk({15'h0000, fault}, 16'h0000);
	endtask
	// Watchdog: the sequence needs about 170 cycles, allow 1000
	initial begin
		#40_000;
		n_fail++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk_route(3'h0);
		chk({12'h000, dbl, gc}, 16'h0008);
		rd_chk(`AIGS_OFF_INPUT, 8'h00);
		rd_chk(`AIGS_OFF_GAIN, 8'h08);
		rd_chk(`AIGS_OFF_STATUS, 8'h18);
		rd_chk(4'h9, 8'h00);
		// Pin mode: register field points elsewhere and must be ignored
		wr_reg(`AIGS_OFF_INPUT, 8'h06);
		wr_reg(`AIGS_OFF_GAIN, 8'h0B);
		@(posedge clk);
		src <= 1'b0;
		ins <= 3'h5;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			ins <= 3'(i);
			gns <= 3'(7 - i);
			settle();
			chk_route(3'(i));
			chk({12'h000, gc, gv}, {12'h000, 3'(7 - i), i != 0});
		end
		// Register mode: pins held at the sleep code
		@(posedge clk);
		src <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr_reg(`AIGS_OFF_INPUT, 8'(i));
			wr_reg(`AIGS_OFF_GAIN, 8'(8 + i));
			settle();
			chk_route(3'(i));
			chk({12'h000, gc, gv}, {12'h000, 3'(i), i != 7});
		end
		rd_chk(`AIGS_OFF_INPUT, 8'h07);
		// Clamp modes with and without pedestal request
		for (int m = 0; m < 3; m++) begin
			for (int p = 0; p < 2; p++) begin
				wr_reg(`AIGS_OFF_CLAMP, 8'(p * 4 + m));
				settle();
				exp_ped = (p == 1 && m == 2);
				chk({12'h000, cm, ped, agcd},
					{12'h000, 2'(m), exp_ped, !exp_ped});
				chk({15'h0000, agca}, 16'h0001);
			end
		end
		// Manual gain: both automatic stages off
		wr_reg(`AIGS_OFF_GAIN, 8'h04);
		settle();
		chk({13'h0000, agca, agcd, gv}, 16'h0001);
		// Single rate sampling by register
		wr_reg(`AIGS_OFF_INPUT, 8'h08);
		settle();
		chk({15'h0000, dbl}, 16'h0000);
		chk_route(3'h0);
		// Mid-run reset after S-video and single rate: defaults return
		wr_reg(`AIGS_OFF_INPUT, 8'h0D);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk_route(3'h0);
		chk({15'h0000, dbl}, 16'h0001);
		rd_chk(`AIGS_OFF_INPUT, 8'h00);
		final_report();
	end
endmodule
